// ===== inc/slice_exec_pkg.sv
// constants, encodings and carriers for the instruction slice executor
// assumes one 200 MHz clock and a machine-cycle enable from a divider
//
// How it works
// - compare-branch: pc plus three, branch if unequal
// - compare sets carry when operand below immediate
// - target is next pc plus signed rel; unsigned compare
// - accumulator clear: zero, one byte, flags kept
// - clear carry or addressed bit, one cycle
// - accumulator complement: invert all bits, flags kept
// - complement carry or addressed bit, one cycle
// - bit complement on ports reads output latch
// - bcd low nibble fix; carry only set
// - bcd high nibble fix; carry only set
// - bcd fixup one cycle, adds 00/06/60/66
// - bcd fixup keeps overflow; carry marks hundreds
// - decrement wraps modulo 256, flags kept
// - decrement forms: acc, bank, indirect, direct
// - decrement on ports reads output latch
package slice_exec_pkg;

  // ---------------------------------------------------------------
  // opcodes and masks
  // ---------------------------------------------------------------
  localparam logic [7:0] OPC_MASK_RN  = 8'hF8;
  localparam logic [7:0] OPC_MASK_RI  = 8'hFE;
  localparam logic [7:0] OPC_COMPARE_BRANCH_UNEQUAL_OP_RN  = 8'hB8;
  localparam logic [7:0] OPC_COMPARE_BRANCH_UNEQUAL_OP_RI  = 8'hB6;
  localparam logic [7:0] OPC_CLR_A    = 8'hE4;
  localparam logic [7:0] OPC_CLR_C    = 8'hC3;
  localparam logic [7:0] OPC_CLR_BIT  = 8'hC2;
  localparam logic [7:0] OPC_CPL_A    = 8'hF4;
  localparam logic [7:0] OPC_CPL_C    = 8'hB3;
  localparam logic [7:0] OPC_CPL_BIT  = 8'hB2;
  localparam logic [7:0] OPC_BCD_FIX  = 8'hD4;
  localparam logic [7:0] OPC_DEC_A    = 8'h14;
  localparam logic [7:0] OPC_DEC_RN   = 8'h18;
  localparam logic [7:0] OPC_DEC_DIR  = 8'h15;
  localparam logic [7:0] OPC_DEC_RI   = 8'h16;

  // ---------------------------------------------------------------
  // arithmetic and timing constants
  // ---------------------------------------------------------------
  localparam logic [7:0]  BYTE_ONE     = 8'h01;
  localparam logic [3:0]  BCD_DIGIT_MAX = 4'h9;
  localparam logic [8:0]  BCD_LOW_ADD  = 9'h006;
  localparam logic [8:0]  BCD_HIGH_ADD = 9'h060;
  localparam logic [8:0]  BCD_NO_ADD   = 9'h000;
  localparam logic [15:0] PC_STEP_1    = 16'h0001;
  localparam logic [15:0] PC_STEP_2    = 16'h0002;
  localparam logic [15:0] PC_STEP_3    = 16'h0003;
  localparam logic [1:0]  MC_ONE       = 2'h1;
  localparam logic [1:0]  MC_TWO       = 2'h2;
  localparam logic [2:0]  BANK_PAGE    = 3'h0;
  localparam logic [1:0]  PTR_SLOT     = 2'h0;
  localparam logic [6:0]  BIT_PAD      = 7'h00;
  localparam int unsigned MCYC_CLKS_DEF = 12;
  localparam int unsigned MCYC_CLKS_MIN = 5;

  // ---------------------------------------------------------------
  // enumerations and carriers
  // ---------------------------------------------------------------
  typedef enum logic [3:0] {
    OP_NONE, OP_COMPARE_BRANCH_UNEQUAL_OP, OP_CLR_A, OP_CLR_C, OP_CLR_BIT, OP_CPL_A,
    OP_CPL_C, OP_CPL_BIT, OP_BCD, OP_DEC_A, OP_DEC_MEM
  } op_t;

  typedef enum logic [2:0] {SRC_NONE, SRC_RN, SRC_RI, SRC_DIR, SRC_BIT}
    src_t;

  typedef struct packed {
    logic       carry;
    logic       half_carry;
    logic       arith_excess;
    logic [1:0] bank;
  } psw_t;

  typedef struct packed {
    logic        req;
    logic        we;
    logic        bit_mode;
    logic        rmw;
    logic [7:0]  addr;
    logic [7:0]  wdata;
  } mem_req_t;

  typedef struct packed {
    logic [7:0]  opcode;
    logic [7:0]  byte2;
    logic [7:0]  byte3;
    logic [15:0] pc;
  } instr_t;

endpackage

// ===== rtl/mcycle_tick.sv
// machine-cycle enable divider
// assumes a single clock and a synchronised active-low reset
`timescale 1ns/100ps
`default_nettype none
module mcycle_tick
  import slice_exec_pkg::*;
#(
  parameter int unsigned CLKS = MCYC_CLKS_DEF
) (
  // clock and reset
  input  wire logic i_sys_clk,
  input  wire logic i_rst_n,
  // enable out
  output logic      o_tick
);

  if (CLKS < MCYC_CLKS_MIN) begin : g_bad_clks
    $error("machine cycle too short for the operand sequence");
  end

  localparam int unsigned CW = $clog2(CLKS);
  localparam logic [CW-1:0] LAST = CW'(CLKS - 1);

  logic [CW-1:0] count;

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      count  <= '0;
      o_tick <= 1'b0;
    end else begin
      count  <= (count == LAST) ? '0 : count + CW'(1);
      o_tick <= (count == LAST);
    end
  end

endmodule
`default_nettype wire

// ===== rtl/bcd_fixup_unit.sv
// decimal adjust of an accumulator after a packed bcd addition
// purely combinational; the caller registers the result
`timescale 1ns/100ps
`default_nettype none
module bcd_fixup_unit
  import slice_exec_pkg::*;
(
  // operands
  input  wire logic       i_carry,
  input  wire logic       i_half_carry,
  input  wire logic [7:0] i_value,
  // result
  output logic [7:0]      o_value,
  output logic            o_carry
);

  logic       low_fix;
  logic [8:0] low_sum;
  logic       mid_carry;
  logic       high_fix;
  logic [8:0] high_sum;

  assign low_fix   = (i_value[3:0] > BCD_DIGIT_MAX) | i_half_carry;
  assign low_sum   = {1'b0, i_value} + (low_fix ? BCD_LOW_ADD : BCD_NO_ADD);
  // carry may only be raised, never dropped
  assign mid_carry = i_carry | low_sum[8];
  assign high_fix  = mid_carry | (low_sum[7:4] > BCD_DIGIT_MAX);
  assign high_sum  = {1'b0, low_sum[7:0]}
                   + (high_fix ? BCD_HIGH_ADD : BCD_NO_ADD);
  assign o_value   = high_sum[7:0];
  assign o_carry   = mid_carry | high_sum[8];

endmodule
`default_nettype wire

// ===== rtl/slice_exec.sv
// executor for compare-branch, clear, complement, bcd fixup, decrement
// assumes an issue source on the same clock and a synchronous data
// memory that answers a request on the following clock; bank
// registers, indirect bytes and bits all live in that memory
`timescale 1ns/100ps
`default_nettype none
module slice_exec
  import slice_exec_pkg::*;
#(
  parameter int unsigned MCYC_CLKS = MCYC_CLKS_DEF
) (
  // clock and reset
  input  wire logic       i_sys_clk,
  input  wire logic       i_rst_n,
  // instruction issue
  input  wire logic       i_issue,
  input  wire instr_t     i_instr,
  // architectural state load
  input  wire logic       i_ld_en,
  input  wire logic [7:0] i_ld_acc,
  input  wire psw_t       i_ld_psw,
  // data memory
  output mem_req_t        o_mem,
  input  wire logic [7:0] i_mem_rdata,
  // status
  output logic            o_mcycle,
  output logic            o_busy,
  output logic            o_done,
  output logic            o_unknown,
  output logic [15:0]     o_pc_next,
  output logic [7:0]      o_acc,
  output psw_t            o_psw
);

  // ---------------------------------------------------------------
  // reset release
  // ---------------------------------------------------------------
  logic rst_meta;
  logic rst_n;

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  logic tick;

  mcycle_tick #(
    .CLKS (MCYC_CLKS)
  ) u_tick (
    .i_sys_clk (i_sys_clk),
    .i_rst_n   (rst_n),
    .o_tick    (tick)
  );

  // ---------------------------------------------------------------
  // decode of the issued opcode
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {S_IDLE, S_PTR, S_OPND, S_EXEC, S_HOLD} state_t;

  state_t      state;
  state_t      next_state;
  instr_t      cur;
  op_t         op;
  psw_t        program_status_word;
  logic [7:0]  acc;
  logic [7:0]  opnd;
  logic [7:0]  opnd_addr;
  logic [15:0] pc_step;
  logic [1:0]  mc_left;
  mem_req_t    next_mem;
  mem_req_t    wr_req;

  logic [7:0] opc;
  logic       is_compare_branch_unequal_op_rn;
  logic       is_compare_branch_unequal_op_ri;
  logic       is_compare_branch_unequal_op;
  logic       is_dec_rn;
  logic       is_dec_ri;
  logic       is_two_byte;
  logic       accept;
  op_t        dec_op;
  src_t       dec_src;
  logic [1:0] dec_mcyc;
  logic [15:0] dec_step;
  logic [7:0] rn_addr;
  logic [7:0] ptr_addr;
  logic [7:0] dec_addr;

  assign opc        = i_instr.opcode;
  assign accept     = (state == S_IDLE) & i_issue & tick;
  assign is_compare_branch_unequal_op_rn = (opc & OPC_MASK_RN) == OPC_COMPARE_BRANCH_UNEQUAL_OP_RN;
  assign is_compare_branch_unequal_op_ri = (opc & OPC_MASK_RI) == OPC_COMPARE_BRANCH_UNEQUAL_OP_RI;
  assign is_dec_rn  = (opc & OPC_MASK_RN) == OPC_DEC_RN;
  assign is_dec_ri  = (opc & OPC_MASK_RI) == OPC_DEC_RI;
  assign is_compare_branch_unequal_op    = is_compare_branch_unequal_op_rn | is_compare_branch_unequal_op_ri;
  assign is_two_byte = (opc == OPC_CLR_BIT) | (opc == OPC_CPL_BIT)
                     | (opc == OPC_DEC_DIR);

  assign dec_op = is_compare_branch_unequal_op                  ? OP_COMPARE_BRANCH_UNEQUAL_OP    :
                  (opc == OPC_CLR_A)       ? OP_CLR_A   :
                  (opc == OPC_CLR_C)       ? OP_CLR_C   :
                  (opc == OPC_CLR_BIT)     ? OP_CLR_BIT :
                  (opc == OPC_CPL_A)       ? OP_CPL_A   :
                  (opc == OPC_CPL_C)       ? OP_CPL_C   :
                  (opc == OPC_CPL_BIT)     ? OP_CPL_BIT :
                  (opc == OPC_BCD_FIX)     ? OP_BCD     :
                  (opc == OPC_DEC_A)       ? OP_DEC_A   :
                  (is_dec_rn | is_dec_ri |
                   (opc == OPC_DEC_DIR))   ? OP_DEC_MEM : OP_NONE;

  assign dec_src = (is_compare_branch_unequal_op_rn | is_dec_rn)  ? SRC_RN  :
                   (is_compare_branch_unequal_op_ri | is_dec_ri)  ? SRC_RI  :
                   (opc == OPC_DEC_DIR)      ? SRC_DIR :
                   (opc == OPC_CPL_BIT)      ? SRC_BIT : SRC_NONE;

  // bank register and pointer slot come straight from the opcode
  assign rn_addr  = {BANK_PAGE, program_status_word.bank, opc[2:0]};
  assign ptr_addr = {BANK_PAGE, program_status_word.bank, PTR_SLOT, opc[0]};
  assign dec_addr = (dec_src == SRC_RN) ? rn_addr : i_instr.byte2;

  assign dec_mcyc = is_compare_branch_unequal_op ? MC_TWO : MC_ONE;
  assign dec_step = is_compare_branch_unequal_op     ? PC_STEP_3 :
                    is_two_byte ? PC_STEP_2 : PC_STEP_1;

  // ---------------------------------------------------------------
  // operand sequence
  // ---------------------------------------------------------------
  always_comb begin
    next_state = state;
    next_mem   = '0;
    unique case (state)
      S_IDLE: begin
        if (accept && dec_src == SRC_RI) begin
          next_state    = S_PTR;
          next_mem.req  = 1'b1;
          next_mem.addr = ptr_addr;
        end else if (accept && dec_src != SRC_NONE) begin
          next_state        = S_OPND;
          next_mem.req      = 1'b1;
          next_mem.addr     = dec_addr;
          next_mem.bit_mode = (dec_src == SRC_BIT);
          // ports hand back their output latch, not the pins, except for the compare, which reads the pins
          next_mem.rmw      = (dec_op != OP_COMPARE_BRANCH_UNEQUAL_OP);
        end else if (accept) begin
          next_state = S_EXEC;
        end
      end
      S_PTR: begin
        next_state    = S_OPND;
        next_mem.req  = 1'b1;
        next_mem.addr = i_mem_rdata;
        next_mem.rmw  = (op == OP_DEC_MEM);
      end
      S_OPND: begin
        next_state = S_EXEC;
      end
      S_EXEC: begin
        next_state = S_HOLD;
        next_mem   = wr_req;
      end
      S_HOLD: begin
        if (tick && mc_left == MC_ONE) begin
          next_state = S_IDLE;
        end
      end
    endcase
  end

  // ---------------------------------------------------------------
  // execution
  // ---------------------------------------------------------------
  logic [7:0]  bcd_value;
  logic        bcd_carry;
  logic        opnd_less;
  logic        opnd_differs;
  logic [15:0] rel_ext;
  logic [15:0] pc_after;
  logic [7:0]  next_acc;
  logic        next_carry;

  bcd_fixup_unit u_bcd (
    .i_carry      (program_status_word.carry),
    .i_half_carry (program_status_word.half_carry),
    .i_value      (acc),
    .o_value      (bcd_value),
    .o_carry      (bcd_carry)
  );

  assign opnd_less    = opnd < cur.byte2;
  assign opnd_differs = opnd != cur.byte2;
  assign rel_ext      = {{8{cur.byte3[7]}}, cur.byte3};
  assign pc_after     = cur.pc + pc_step
                      + ((op == OP_COMPARE_BRANCH_UNEQUAL_OP && opnd_differs) ? rel_ext
                                                         : '0);

  always_comb begin
    next_acc   = acc;
    next_carry = program_status_word.carry;
    wr_req     = '0;
    unique case (op)
      OP_COMPARE_BRANCH_UNEQUAL_OP:    next_carry = opnd_less;
      OP_CLR_A:   next_acc = '0;
      OP_CLR_C:   next_carry = 1'b0;
      OP_CLR_BIT: wr_req = '{req: 1'b1, we: 1'b1, bit_mode: 1'b1,
                             rmw: 1'b1, addr: cur.byte2,
                             wdata: '0};
      OP_CPL_A:   next_acc = ~acc;
      OP_CPL_C:   next_carry = ~program_status_word.carry;
      OP_CPL_BIT: wr_req = '{req: 1'b1, we: 1'b1, bit_mode: 1'b1,
                             rmw: 1'b1, addr: cur.byte2,
                             wdata: {BIT_PAD, ~opnd[0]}};
      OP_BCD: begin
        next_acc   = bcd_value;
        next_carry = bcd_carry;
      end
      OP_DEC_A:   next_acc = acc - BYTE_ONE;
      OP_DEC_MEM: wr_req = '{req: 1'b1, we: 1'b1, bit_mode: 1'b0,
                             rmw: 1'b1, addr: opnd_addr,
                             wdata: opnd - BYTE_ONE};
      OP_NONE:    next_acc = acc;
    endcase
  end

  // ---------------------------------------------------------------
  // state registers
  // ---------------------------------------------------------------
  always_ff @(posedge i_sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= S_IDLE;
      o_mem <= '0;
    end else begin
      state <= next_state;
      o_mem <= next_mem;
    end
  end

  always_ff @(posedge i_sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cur     <= '0;
      op      <= OP_NONE;
      pc_step <= PC_STEP_1;
      mc_left <= MC_ONE;
    end else if (accept) begin
      cur     <= i_instr;
      op      <= dec_op;
      pc_step <= dec_step;
      mc_left <= dec_mcyc;
    end else if (tick && state != S_IDLE) begin
      mc_left <= mc_left - MC_ONE;
    end
  end

  always_ff @(posedge i_sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      opnd      <= '0;
      opnd_addr <= '0;
    end else if (accept) begin
      opnd_addr <= dec_addr;
    end else if (state == S_PTR) begin
      opnd_addr <= i_mem_rdata;
    end else if (state == S_OPND) begin
      opnd      <= i_mem_rdata;
    end
  end

  // execution only changes the carry and accumulator; other flags are kept until an idle load
  always_ff @(posedge i_sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      acc <= '0;
      program_status_word <= '0;
    end else if (state == S_EXEC) begin
      acc       <= next_acc;
      program_status_word.carry <= next_carry;
    end else if (state == S_IDLE && i_ld_en) begin
      acc <= i_ld_acc;
      program_status_word <= i_ld_psw;
    end
  end

  always_ff @(posedge i_sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_done    <= 1'b0;
      o_unknown <= 1'b0;
      o_busy    <= 1'b0;
      o_pc_next <= '0;
    end else begin
      o_done    <= (state == S_HOLD) & tick & (mc_left == MC_ONE);
      o_unknown <= (state == S_HOLD) & tick & (mc_left == MC_ONE)
                 & (op == OP_NONE);
      o_busy    <= (next_state != S_IDLE);
      if (state == S_HOLD && tick && mc_left == MC_ONE) begin
        o_pc_next <= pc_after;
      end
    end
  end

  assign o_mcycle = tick;
  assign o_acc    = acc;
  assign o_psw    = program_status_word;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  logic [1:0] mc_seen;
  logic [1:0] mc_want;

  always_ff @(posedge i_sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      mc_seen <= '0;
      mc_want <= '0;
    end else if (accept) begin
      mc_seen <= '0;
      mc_want <= dec_mcyc;
    end else if (tick && state != S_IDLE) begin
      mc_seen <= mc_seen + MC_ONE;
    end
  end

  property p_cycle_count;
    @(posedge i_sys_clk) disable iff (!rst_n)
    o_done |-> (mc_seen == mc_want) && (mc_want == (op == OP_COMPARE_BRANCH_UNEQUAL_OP ? 2 : 1));
  endproperty
  a_cycle_count: assert property (p_cycle_count)
    else $error("instruction length in machine cycles wrong");

  property p_compare_branch_unequal_op_carry;
    @(posedge i_sys_clk) disable iff (!rst_n)
    (state == S_EXEC && op == OP_COMPARE_BRANCH_UNEQUAL_OP)
      |=> program_status_word.carry == ($past(opnd) < $past(cur.byte2));
  endproperty
  a_compare_branch_unequal_op_carry: assert property (p_compare_branch_unequal_op_carry)
    else $error("compare carry wrong");

  property p_compare_branch_unequal_op_target;
    @(posedge i_sys_clk) disable iff (!rst_n)
    (o_done && op == OP_COMPARE_BRANCH_UNEQUAL_OP)
      |-> o_pc_next == cur.pc + 16'h0003
          + ((opnd != cur.byte2) ? {{8{cur.byte3[7]}}, cur.byte3} : '0);
  endproperty
  a_compare_branch_unequal_op_target: assert property (p_compare_branch_unequal_op_target)
    else $error("branch target wrong");

  property p_clr_acc;
    @(posedge i_sys_clk) disable iff (!rst_n)
    (state == S_EXEC && op == OP_CLR_A)
      |=> acc == 8'h00 && program_status_word == $past(program_status_word);
  endproperty
  a_clr_acc: assert property (p_clr_acc)
    else $error("accumulator clear wrong");

  property p_cpl_acc;
    @(posedge i_sys_clk) disable iff (!rst_n)
    (state == S_EXEC && op == OP_CPL_A) |=> acc == ~$past(acc);
  endproperty
  a_cpl_acc: assert property (p_cpl_acc)
    else $error("accumulator complement wrong");

  property p_cpl_carry;
    @(posedge i_sys_clk) disable iff (!rst_n)
    (state == S_EXEC && op == OP_CPL_C) |=> program_status_word.carry != $past(program_status_word.carry);
  endproperty
  a_cpl_carry: assert property (p_cpl_carry)
    else $error("carry complement wrong");

  property p_rmw_latch;
    @(posedge i_sys_clk) disable iff (!rst_n)
    (state == S_OPND && (op == OP_DEC_MEM || op == OP_CPL_BIT))
      |-> o_mem.req && o_mem.rmw && !o_mem.we;
  endproperty
  a_rmw_latch: assert property (p_rmw_latch)
    else $error("read-modify-write read not marked");

  property p_bcd_carry_kept;
    @(posedge i_sys_clk) disable iff (!rst_n)
    (state == S_EXEC && op == OP_BCD && program_status_word.carry)
      |=> program_status_word.carry && program_status_word.arith_excess == $past(program_status_word.arith_excess);
  endproperty
  a_bcd_carry_kept: assert property (p_bcd_carry_kept)
    else $error("bcd fixup dropped carry or touched overflow");

  property p_dec_wrap;
    @(posedge i_sys_clk) disable iff (!rst_n)
    (state == S_EXEC && op == OP_DEC_A)
      |=> acc == $past(acc) - 8'h01 && program_status_word == $past(program_status_word);
  endproperty
  a_dec_wrap: assert property (p_dec_wrap)
    else $error("accumulator decrement wrong");

endmodule
`default_nettype wire

// ===== verif/slice_exec_tb.sv
// testbench for slice_exec: a table of instructions, then reset cases
// assumes one 200 MHz clock; data memory and port latches live here
`timescale 1ns/100ps
`default_nettype none
module slice_exec_tb;
  import slice_exec_pkg::*;

  // ---------------------------------------------------------------
  // clock, reset and design
  // ---------------------------------------------------------------
  localparam int unsigned MC = 5;
  typedef struct packed {
    logic [7:0]  opc, b2, b3, acc;
    logic        c, ac;
    logic [1:0]  bk, mk;
    logic [7:0]  maddr, minit, mexp, eacc;
    logic        ec;
    logic [15:0] epc;
  } row_t;

  logic        i_sys_clk = 1'b0;
  logic        i_rst_n, i_issue, i_ld_en;
  instr_t      i_instr;
  logic [7:0]  i_ld_acc, i_mem_rdata;
  psw_t        i_ld_psw;
  mem_req_t    o_mem;
  logic        o_mcycle, o_busy, o_done, o_unknown;
  logic [15:0] o_pc_next;
  logic [7:0]  o_acc;
  psw_t        o_psw;
  logic [7:0]  mem [256];
  logic        bitm [256];
  int          n_fail = 0;
  int          checks_done = 0;
  int          n_wr = 0;

  always #2.5 i_sys_clk = ~i_sys_clk;

  slice_exec #(.MCYC_CLKS(MC)) i_slice_exec (
    .i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_issue(i_issue),
    .i_instr(i_instr), .i_ld_en(i_ld_en), .i_ld_acc(i_ld_acc),
    .i_ld_psw(i_ld_psw), .o_mem(o_mem), .i_mem_rdata(i_mem_rdata),
    .o_mcycle(o_mcycle), .o_busy(o_busy), .o_done(o_done),
    .o_unknown(o_unknown), .o_pc_next(o_pc_next), .o_acc(o_acc),
    .o_psw(o_psw)
  );

  // ---------------------------------------------------------------
  // data memory; addresses from 80 up act as port latches
  // ---------------------------------------------------------------
  function automatic logic [7:0] rd_val(input mem_req_t q);
    logic [7:0] v;
    v = q.bit_mode ? {7'h2A, bitm[q.addr]} : mem[q.addr];
    // pins read back inverted so a latch read can be told apart
    if (q.addr[7] && !q.rmw) v = ~v;
    return v;
  endfunction

  // the design samples read data at the edge after its registered request
  always_comb begin
    if (o_mem.req && !o_mem.we) i_mem_rdata = rd_val(o_mem);
    else i_mem_rdata = 8'hA5;
  end

  always @(posedge i_sys_clk) begin
    if (o_mem.req && o_mem.we) begin
      n_wr <= n_wr + 1;
      if (o_mem.bit_mode) bitm[o_mem.addr] <= o_mem.wdata[0];
      else mem[o_mem.addr] <= o_mem.wdata;
    end
  end

  // ---------------------------------------------------------------
  // comparisons and verdict
  // ---------------------------------------------------------------
  task automatic chk_byte(input string nm, input logic [7:0] e,
                          input logic [7:0] g);
    checks_done++;
    if (g !== e) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic chk_word(input string nm, input logic [15:0] e,
                          input logic [15:0] g);
    checks_done++;
    if (g !== e) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic chk_psw(input string nm, input psw_t e, input psw_t g);
    checks_done++;
    if (g !== e) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic give_verdict;
    $display("checks %0d, failures %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  // ---------------------------------------------------------------
  // reset and one instruction
  // ---------------------------------------------------------------
  task automatic do_reset;
    i_rst_n <= 1'b0;
    repeat (6) @(posedge i_sys_clk);
    chk_byte("busy in reset", 8'h00, {7'h00, o_busy});
    chk_byte("acc in reset", 8'h00, o_acc);
    chk_word("pc in reset", 16'h0000, o_pc_next);
    chk_psw("psw in reset", 5'h00, o_psw);
    i_rst_n <= 1'b1;
    // internal reset lets go two edges later; loads before that are lost
    repeat (3) @(posedge i_sys_clk);
  endtask

  task automatic run_row(input row_t r);
    int   k;
    int   ticks;
    logic unk;
    ticks = 0;
    unk = 1'b0;
    if (r.mk == 2'h1) mem[r.maddr] = r.minit;
    if (r.mk == 2'h2) bitm[r.maddr] = r.minit[0];
    if (r.opc[7:1] == 7'h5B || r.opc[7:1] == 7'h0B)
      mem[{3'h0, r.bk, 2'h0, r.opc[0]}] = r.maddr;
    n_wr = 0;
    i_ld_acc <= r.acc;
    i_ld_psw <= '{r.c, r.ac, 1'b1, r.bk};
    i_ld_en <= 1'b1;
    @(posedge i_sys_clk);
    i_ld_en <= 1'b0;
    i_instr <= '{r.opc, r.b2, r.b3, 16'h0100};
    i_issue <= 1'b1;
    for (k = 0; k < 80 && o_done !== 1'b1; k++) begin
      @(posedge i_sys_clk);
      if (o_busy === 1'b1) i_issue <= 1'b0;
      if (o_busy === 1'b1 && o_mcycle === 1'b1) ticks++;
      unk = o_unknown;
    end
    if (k == 80) begin
      n_fail++;
      give_verdict();
    end
    chk_word("next pc", r.epc, o_pc_next);
    chk_byte("acc", r.eacc, o_acc);
    chk_psw("status", '{r.ec, r.ac, 1'b1, r.bk}, o_psw);
    chk_byte("unknown", {7'h00, r.opc == 8'h00}, {7'h00, unk});
    chk_byte("mcycles", (r.opc[7:1] == 7'h5B || r.opc[7:3] == 5'h17)
             ? 8'h02 : 8'h01, 8'(ticks));
    @(posedge i_sys_clk);
    if (r.mk == 2'h1) chk_byte("memory", r.mexp, mem[r.maddr]);
    if (r.mk == 2'h2) chk_byte("bit", r.mexp, {7'h00, bitm[r.maddr]});
    chk_byte("writes", (r.mk != 2'h0 && r.opc[7:4] != 4'hB ||
             r.opc == 8'hB2) ? 8'h01 : 8'h00, 8'(n_wr));
  endtask

  // ---------------------------------------------------------------
  // table: opc b2 b3 acc c ac bank kind addr init exp acc c pc
  // ---------------------------------------------------------------
  row_t rows [21] = '{
    '{8'hBB,8'h60,8'h10,8'h34,1'b0,1'b0,2'h0,2'h1,8'h03,8'h56,8'h56,8'h34,1'b1,16'h0113},
    '{8'hBF,8'h42,8'h10,8'h34,1'b1,1'b0,2'h0,2'h1,8'h07,8'h42,8'h42,8'h34,1'b0,16'h0103},
    '{8'hB7,8'h05,8'hF0,8'h34,1'b1,1'b0,2'h0,2'h1,8'h40,8'hC8,8'hC8,8'h34,1'b0,16'h00F3},
    '{8'hB6,8'hFF,8'h7F,8'h34,1'b0,1'b0,2'h0,2'h1,8'h41,8'h80,8'h80,8'h34,1'b1,16'h0182},
    '{8'hE4,8'h00,8'h00,8'h5C,1'b1,1'b1,2'h0,2'h0,8'h00,8'h00,8'h00,8'h00,1'b1,16'h0101},
    '{8'hC3,8'h00,8'h00,8'hA5,1'b1,1'b0,2'h0,2'h0,8'h00,8'h00,8'h00,8'hA5,1'b0,16'h0101},
    '{8'hC2,8'h2C,8'h00,8'hA5,1'b1,1'b0,2'h0,2'h2,8'h2C,8'h01,8'h00,8'hA5,1'b1,16'h0102},
    '{8'hF4,8'h00,8'h00,8'h5C,1'b0,1'b1,2'h0,2'h0,8'h00,8'h00,8'h00,8'hA3,1'b0,16'h0101},
    '{8'hB3,8'h00,8'h00,8'h3C,1'b0,1'b0,2'h0,2'h0,8'h00,8'h00,8'h00,8'h3C,1'b1,16'h0101},
    '{8'hB2,8'h91,8'h00,8'h3C,1'b1,1'b0,2'h0,2'h2,8'h91,8'h01,8'h00,8'h3C,1'b1,16'h0102},
    '{8'hD4,8'h00,8'h00,8'hBE,1'b0,1'b0,2'h0,2'h0,8'h00,8'h00,8'h00,8'h24,1'b1,16'h0101},
    '{8'hD4,8'h00,8'h00,8'hC9,1'b0,1'b0,2'h0,2'h0,8'h00,8'h00,8'h00,8'h29,1'b1,16'h0101},
    '{8'hD4,8'h00,8'h00,8'h29,1'b0,1'b1,2'h0,2'h0,8'h00,8'h00,8'h00,8'h2F,1'b0,16'h0101},
    '{8'hD4,8'h00,8'h00,8'h12,1'b1,1'b0,2'h0,2'h0,8'h00,8'h00,8'h00,8'h72,1'b1,16'h0101},
    '{8'hD4,8'h00,8'h00,8'hFA,1'b0,1'b0,2'h0,2'h0,8'h00,8'h00,8'h00,8'h60,1'b1,16'h0101},
    '{8'hD4,8'h00,8'h00,8'h9A,1'b0,1'b0,2'h0,2'h0,8'h00,8'h00,8'h00,8'h00,1'b1,16'h0101},
    '{8'h14,8'h00,8'h00,8'h00,1'b1,1'b0,2'h0,2'h0,8'h00,8'h00,8'h00,8'hFF,1'b1,16'h0101},
    '{8'h1D,8'h00,8'h00,8'h34,1'b0,1'b0,2'h2,2'h1,8'h15,8'h00,8'hFF,8'h34,1'b0,16'h0101},
    '{8'h15,8'h90,8'h00,8'h34,1'b0,1'b0,2'h0,2'h1,8'h90,8'h37,8'h36,8'h34,1'b0,16'h0102},
    '{8'h17,8'h00,8'h00,8'h34,1'b0,1'b0,2'h0,2'h1,8'h7F,8'h40,8'h3F,8'h34,1'b0,16'h0101},
    '{8'h00,8'h00,8'h00,8'h34,1'b1,1'b0,2'h0,2'h0,8'h00,8'h00,8'h00,8'h34,1'b1,16'h0101}
  };

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    int k;
    i_rst_n = 1'b0;
    i_issue = 1'b0;
    i_ld_en = 1'b0;
    i_instr = '0;
    i_ld_acc = 8'h00;
    i_ld_psw = '0;
    do_reset();
    foreach (rows[i]) run_row(rows[i]);
    // reset in mid-instruction, then the same compare runs cleanly
    i_instr <= '{8'hBB, 8'h60, 8'h10, 16'h0100};
    i_issue <= 1'b1;
    for (k = 0; k < 40 && o_busy !== 1'b1; k++) @(posedge i_sys_clk);
    i_issue <= 1'b0;
    repeat (3) @(posedge i_sys_clk);
    chk_byte("busy before reset", 8'h01, {7'h00, o_busy});
    do_reset();
    run_row(rows[0]);
    give_verdict();
  end
endmodule
`default_nettype wire
